// ===== inc/rts_pkg.sv
package rts_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SHORT_NS = 8000;
  localparam int unsigned OPEN_NS = 2000;
  localparam int unsigned CHARGE_NS = 1000;
  localparam int unsigned PORT_BASE_NS = 128000;
  // Least times round up, longest times round down
  localparam int unsigned SHORT_CYC =
    (SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OPEN_CYC = OPEN_NS / CLK_PERIOD_NS;
  localparam int unsigned CHARGE_CYC =
    (CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PORT_BASE_CYC = PORT_BASE_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 20;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_REF_INT = 8'h0C;
  localparam logic [7:0] ADR_REF_FRAC = 8'h10;
  localparam logic [7:0] ADR_SNS_INT = 8'h14;
  localparam logic [7:0] ADR_SNS_FRAC = 8'h18;

  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_PRE_LSB = 1;
  localparam int unsigned CTRL_INT_LSB = 4;
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_OPEN_BIT = 1;
  localparam int unsigned ST_BUSY_BIT = 8;
  localparam int unsigned ST_REF_RNG_LSB = 9;
  localparam int unsigned ST_SNS_RNG_LSB = 12;

  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic [1:0] INT_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [15:0] RES_ZERO = 16'h0000;
  localparam logic [15:0] RES_ONES = 16'hFFFF;
  localparam logic [CNT_W-1:0] RANGE_LIMIT = 20'h08000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rts_wb_req_t;

  typedef enum logic [1:0] {
    TM_IDLE,
    TM_CHARGE,
    TM_DISCH,
    TM_HOLD
  } rts_tm_state_t;

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_DUMMY,
    SQ_EVAL,
    SQ_REAL
  } rts_sq_state_t;

endpackage : rts_pkg

// ===== rtl/rts_sequencer.sv
// Notes on behaviour
// - Dummy cycles discharge through the internal emulation resistor.
// - Preamble field sets zero to seven dummy cycles before evaluation.
// - A coarse evaluate cycle precedes real measurements automatically.
// - Evaluate result picks the range shift for the real measurement.
// - Port interval field sets start-to-start spacing of port slots.
// - After all ports finish, integer and fraction results are written.
// - Completion sets the done flag and asserts the low interrupt when mask bit 0 is set.
// - Charge pin charges the capacitor; time measured through chosen port.
// - A reading under eight microseconds stores all zeros.
// - No discharge within 2 us past slot: all ones, open flag.
//
// Added by the designer: register access over Wishbone and the register addresses.
module rts_sequencer #(
  parameter int unsigned CNT_W = rts_pkg::CNT_W,
  parameter int unsigned PORT_BASE_CYC = rts_pkg::PORT_BASE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire rts_pkg::rts_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Temperature pins
  input wire logic cmp_i,
  output logic charge_pin_o,
  output logic emul_sel_o,
  output logic reference_port_sel_o,
  output logic sensor_port_sel_o,
  // Interrupt
  output logic irq_n_o
);
  import rts_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  rts_sq_state_t sq_reg;
  logic [2:0] preamble_count_field_reg;
  logic [1:0] port_interval_field_reg;
  logic [1:0] mask_reg;
  logic temp_done_flag_reg;
  logic open_probe_flag_reg;
  logic [2:0] dummy_left_reg;
  logic port_reg;
  logic start_reg;
  logic [1:0] port_open_reg;
  logic [2:0] range_reg [2];
  logic [15:0] pend_int_reg [2];
  logic [15:0] pend_frac_reg [2];
  logic [15:0] port_result_integer_reg [2];
  logic [15:0] port_result_fraction_reg [2];
  logic [CNT_W-1:0] slot_cyc_reg;
  logic [2:0] range_next;

  logic tm_charge;
  logic tm_done;
  logic tm_open;
  logic [CNT_W-1:0] tm_time;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire logic bus_req = wb_i.cyc && wb_i.stb && !wb_ack_o;
  wire logic bus_wr = bus_req && wb_i.we && wb_i.sel[0];
  wire logic wr_ctrl = bus_wr && (wb_i.adr == ADR_CTRL);
  wire logic wr_status = bus_wr && (wb_i.adr == ADR_STATUS);
  wire logic wr_mask = bus_wr && (wb_i.adr == ADR_MASK);
  wire logic busy = sq_reg != SQ_IDLE;
  wire logic start_req = wr_ctrl && wb_i.dat[CTRL_START_BIT] && !busy;

  wire logic [31:0] status_word =
    {17'h0, range_reg[1], range_reg[0], busy, 6'h0,
     open_probe_flag_reg, temp_done_flag_reg};
  wire logic [31:0] rd_data =
    (wb_i.adr == ADR_CTRL) ?
      {26'h0, port_interval_field_reg, preamble_count_field_reg, 1'b0} :
    (wb_i.adr == ADR_STATUS) ? status_word :
    (wb_i.adr == ADR_MASK) ? {30'h0, mask_reg} :
    (wb_i.adr == ADR_REF_INT) ? {16'h0, port_result_integer_reg[0]} :
    (wb_i.adr == ADR_REF_FRAC) ? {16'h0, port_result_fraction_reg[0]} :
    (wb_i.adr == ADR_SNS_INT) ? {16'h0, port_result_integer_reg[1]} :
    (wb_i.adr == ADR_SNS_FRAC) ? {16'h0, port_result_fraction_reg[1]} :
    32'h0000_0000;

  // ------------------------------------------------------------
  // Measurement arithmetic
  // ------------------------------------------------------------
  // Interval comes with the start write itself
  wire logic [CNT_W-1:0] slot_cyc_next =
    CNT_W'((32'(wb_i.dat[CTRL_INT_LSB +: 2]) + 32'h1) * PORT_BASE_CYC);
  wire logic real_short = tm_time < CNT_W'(SHORT_CYC);
  wire logic [CNT_W+15:0] scaled =
    {tm_time, 16'h0000} >> range_reg[port_reg];
  wire logic real_open = tm_open || port_open_reg[port_reg];
  wire logic last_dummy = dummy_left_reg <= 3'h1;
  wire logic seq_end = (sq_reg == SQ_REAL) && tm_done && port_reg;

  // Smallest shift that keeps the coarse time inside 15 bits
  always_comb
  begin
    range_next = 3'h7;
    for (int i = 7; i >= 0; i--)
    begin
      if ((tm_time >> i) < RANGE_LIMIT)
        range_next = 3'(i);
    end
  end

  // ------------------------------------------------------------
  // Slot timer
  // ------------------------------------------------------------
  rts_slot_timer #(
    .CNT_W(CNT_W)
  ) u_slot (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(start_reg),
    .slot_cyc_i(slot_cyc_reg),
    .cmp_i(cmp_i),
    .charge_o(tm_charge),
    .done_o(tm_done),
    .open_o(tm_open),
    .time_o(tm_time)
  );

  // ------------------------------------------------------------
  // Bus slave and configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      preamble_count_field_reg <= PRE_RST;
      port_interval_field_reg <= INT_RST;
      mask_reg <= MASK_RST;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
      if (wr_ctrl && !busy)
      begin
        preamble_count_field_reg <= wb_i.dat[CTRL_PRE_LSB +: 3];
        port_interval_field_reg <= wb_i.dat[CTRL_INT_LSB +: 2];
      end
      if (wr_mask)
        mask_reg <= wb_i.dat[1:0];
    end
  end

  // ------------------------------------------------------------
  // Sticky flags and interrupt
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      temp_done_flag_reg <= 1'b0;
      open_probe_flag_reg <= 1'b0;
      irq_n_o <= 1'b1;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      if (seq_end)
        temp_done_flag_reg <= 1'b1;
      else if (wr_status && wb_i.dat[ST_DONE_BIT])
        temp_done_flag_reg <= 1'b0;
      if (seq_end && (port_open_reg != 2'h0 || tm_open))
        open_probe_flag_reg <= 1'b1;
      else if (wr_status && wb_i.dat[ST_OPEN_BIT])
        open_probe_flag_reg <= 1'b0;
      irq_n_o <= !(|({open_probe_flag_reg, temp_done_flag_reg}
                   & mask_reg));
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_pin_o <= 1'b0;
      emul_sel_o <= 1'b0;
      reference_port_sel_o <= 1'b0;
      sensor_port_sel_o <= 1'b0;
    end
    else
    begin
      charge_pin_o <= tm_charge;
      emul_sel_o <= sq_reg == SQ_DUMMY;
      reference_port_sel_o <= (sq_reg == SQ_EVAL || sq_reg == SQ_REAL)
                              && !port_reg;
      sensor_port_sel_o <= (sq_reg == SQ_EVAL || sq_reg == SQ_REAL)
                           && port_reg;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sq_reg <= SQ_IDLE;
      dummy_left_reg <= 3'h0;
      port_reg <= 1'b0;
      start_reg <= 1'b0;
      port_open_reg <= 2'h0;
      slot_cyc_reg <= '0;
      for (int p = 0; p < 2; p++)
      begin
        range_reg[p] <= 3'h0;
        pend_int_reg[p] <= RES_ZERO;
        pend_frac_reg[p] <= RES_ZERO;
        port_result_integer_reg[p] <= RES_ZERO;
        port_result_fraction_reg[p] <= RES_ZERO;
      end
    end
    else
    begin
      start_reg <= 1'b0;
      case (sq_reg)
        SQ_IDLE:
        begin
          if (start_req)
          begin
            slot_cyc_reg <= slot_cyc_next;
            port_reg <= 1'b0;
            port_open_reg <= 2'h0;
            start_reg <= 1'b1;
            dummy_left_reg <= wb_i.dat[CTRL_PRE_LSB +: 3];
            if (wb_i.dat[CTRL_PRE_LSB +: 3] != 3'h0)
              sq_reg <= SQ_DUMMY;
            else
              sq_reg <= SQ_EVAL;
          end
        end
        SQ_DUMMY:
        begin
          if (tm_done)
          begin
            start_reg <= 1'b1;
            dummy_left_reg <= dummy_left_reg - 3'h1;
            if (last_dummy)
              sq_reg <= SQ_EVAL;
          end
        end
        SQ_EVAL:
        begin
          if (tm_done)
          begin
            start_reg <= 1'b1;
            range_reg[port_reg] <= range_next;
            if (tm_open)
              port_open_reg[port_reg] <= 1'b1;
            port_reg <= !port_reg;
            if (port_reg)
              sq_reg <= SQ_REAL;
          end
        end
        SQ_REAL:
        begin
          if (tm_done)
          begin
            if (tm_open)
              port_open_reg[port_reg] <= 1'b1;
            if (real_open)
            begin
              pend_int_reg[port_reg] <= RES_ONES;
              pend_frac_reg[port_reg] <= RES_ONES;
            end
            else if (real_short)
            begin
              pend_int_reg[port_reg] <= RES_ZERO;
              pend_frac_reg[port_reg] <= RES_ZERO;
            end
            else
            begin
              pend_int_reg[port_reg] <= scaled[31:16];
              pend_frac_reg[port_reg] <= scaled[15:0];
            end
            if (!port_reg)
            begin
              port_reg <= 1'b1;
              start_reg <= 1'b1;
            end
            else
              sq_reg <= SQ_IDLE;
          end
        end
        default:
          sq_reg <= SQ_IDLE;
      endcase
      // Commit all ports together once the sensor port is finished
      if (seq_end)
      begin
        port_result_integer_reg[0] <= pend_int_reg[0];
        port_result_fraction_reg[0] <= pend_frac_reg[0];
        port_result_integer_reg[1] <=
          real_open ? RES_ONES : real_short ? RES_ZERO : scaled[31:16];
        port_result_fraction_reg[1] <=
          real_open ? RES_ONES : real_short ? RES_ZERO : scaled[15:0];
      end
    end
  end

endmodule : rts_sequencer

// ===== rtl/rts_slot_timer.sv
module rts_slot_timer #(
  parameter int unsigned CNT_W = rts_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  input wire logic [CNT_W-1:0] slot_cyc_i,
  // Analog side
  input wire logic cmp_i,
  output logic charge_o,
  // Result
  output logic done_o,
  output logic open_o,
  output logic [CNT_W-1:0] time_o
);
  import rts_pkg::*;

  rts_tm_state_t state_reg;
  logic [CNT_W-1:0] slot_cnt_reg;
  logic [CNT_W-1:0] meas_cnt_reg;

  wire logic charge_end = slot_cnt_reg >= CNT_W'(CHARGE_CYC - 1);
  wire logic open_hit = slot_cnt_reg >= slot_cyc_i + CNT_W'(OPEN_CYC);
  wire logic slot_end = slot_cnt_reg >= slot_cyc_i - CNT_W'(1);

  assign time_o = meas_cnt_reg;

  // ------------------------------------------------------------
  // One port slot: charge, discharge, hold to slot end
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= TM_IDLE;
      slot_cnt_reg <= '0;
      meas_cnt_reg <= '0;
      charge_o <= 1'b0;
      done_o <= 1'b0;
      open_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_reg)
        TM_IDLE:
        begin
          if (start_i)
          begin
            slot_cnt_reg <= '0;
            meas_cnt_reg <= '0;
            open_o <= 1'b0;
            charge_o <= 1'b1;
            state_reg <= TM_CHARGE;
          end
        end
        TM_CHARGE:
        begin
          slot_cnt_reg <= slot_cnt_reg + CNT_W'(1);
          if (charge_end)
          begin
            charge_o <= 1'b0;
            state_reg <= TM_DISCH;
          end
        end
        TM_DISCH:
        begin
          slot_cnt_reg <= slot_cnt_reg + CNT_W'(1);
          if (!cmp_i)
            state_reg <= TM_HOLD;
          else if (open_hit)
          begin
            open_o <= 1'b1;
            state_reg <= TM_HOLD;
          end
          else
            meas_cnt_reg <= meas_cnt_reg + CNT_W'(1);
        end
        TM_HOLD:
        begin
          slot_cnt_reg <= slot_cnt_reg + CNT_W'(1);
          if (slot_end)
          begin
            done_o <= 1'b1;
            state_reg <= TM_IDLE;
          end
        end
        default:
          state_reg <= TM_IDLE;
      endcase
    end
  end

endmodule : rts_slot_timer

// ===== verif/rts_rc_model.sv
module rts_rc_model (
  // Clock
  input wire logic clk_i,
  // Pins from the sequencer
  input wire logic charge_i,
  input wire logic emul_i,
  input wire logic ref_i,
  input wire logic sns_i,
  // Discharge times in cycles
  input wire logic [31:0] ref_t_i,
  input wire logic [31:0] sns_t_i,
  // Comparator
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt = 32'h0;
  logic [31:0] lim;
  initial cmp_o = 1'b0;
  // ----
  // Discharge through the selected path
  // ----
  assign lim = emul_i ? 32'h352 :
    ref_i ? ref_t_i : sns_i ? sns_t_i : 32'h0;
  always @(posedge clk_i)
  begin
    cnt <= charge_i ? 32'h0 : cnt + 1;
    if (charge_i)
      cmp_o <= 1'b1;
    else if (cnt + 1 >= lim)
      cmp_o <= 1'b0;
  end
endmodule : rts_rc_model

// ===== verif/rts_seq_sva.sv
module rts_seq_sva #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned PORT_BASE_CYC = 12800
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire rts_pkg::rts_wb_req_t wb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins
  input wire logic cmp_i,
  input wire logic charge_pin_o,
  input wire logic emul_sel_o,
  input wire logic reference_port_sel_o,
  input wire logic sensor_port_sel_o,
  input wire logic irq_n_o
);
  import rts_pkg::*;
  localparam int unsigned SLOT_MIN = PORT_BASE_CYC - 4;
  localparam int unsigned SLOT_MAX = 4 * PORT_BASE_CYC + OPEN_CYC + 4;
  int unsigned chg_cnt;
  int unsigned ref_cnt;
  logic ref_seen;
  logic any_sel;
  assign any_sel = emul_sel_o | reference_port_sel_o | sensor_port_sel_o;
  // ----
  // Helper counters
  // ----
  always_ff @(posedge clk_i)
  begin
    chg_cnt <= (rst_i || !charge_pin_o) ? 0 : chg_cnt + 1;
    ref_cnt <= (rst_i || !reference_port_sel_o) ? 0 : ref_cnt + 1;
    ref_seen <= !rst_i &&
      (reference_port_sel_o || (ref_seen && !sensor_port_sel_o));
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_s;
    wb_i.cyc && wb_i.stb && !wb_ack_o;
  endsequence
  sequence pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_pulse_a: assert property (req_s |=> pulse_s)
    else $error("ack not a single pulse");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_i.stb))
    else $error("ack without request");
  sel_onehot_a: assert property ($onehot0({emul_sel_o,
    reference_port_sel_o, sensor_port_sel_o}))
    else $error("two paths selected");
  charge_len_a: assert property ($fell(charge_pin_o) |->
    chg_cnt == CHARGE_CYC) else $error("charge length wrong");
  slot_len_a: assert property ($fell(reference_port_sel_o) |->
    ref_cnt >= SLOT_MIN && ref_cnt <= SLOT_MAX)
    else $error("slot length wrong");
  port_order_a: assert property ($rose(sensor_port_sel_o) |->
    ref_seen) else $error("sensor before reference");
  irq_idle_a: assert property ($fell(irq_n_o) |-> !any_sel)
    else $error("interrupt during a slot");
  reset_quiet_a: assert property ($fell(rst_i) |-> irq_n_o &&
    !charge_pin_o && !wb_ack_o && !any_sel)
    else $error("outputs active in reset");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
endmodule : rts_seq_sva

bind rts_sequencer rts_seq_sva #(.CNT_W(CNT_W),
  .PORT_BASE_CYC(PORT_BASE_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_i(cmp_i),
  .charge_pin_o(charge_pin_o), .emul_sel_o(emul_sel_o),
  .reference_port_sel_o(reference_port_sel_o),
  .sensor_port_sel_o(sensor_port_sel_o), .irq_n_o(irq_n_o));

// ===== verif/tb_rc_temperature_sequencer.sv
module tb_rc_temperature_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import rts_pkg::*;
  localparam int BASE = 1100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  rts_wb_req_t wb_i = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic cmp_i;
  logic chg;
  logic emul;
  logic rsel;
  logic ssel;
  logic irq_n_o;
  logic [31:0] ref_t = 32'h0;
  logic [31:0] sns_t = 32'h0;
  logic [31:0] lfsr = 32'hADD9;
  logic [3:0] order = 4'h0;
  logic [1:0] msk [4] = '{2'h1, 2'h0, 2'h1, 2'h2};
  int n_fail = 0;
  int comparisons = 0;
  int n_cyc = 0;
  int n_dummy = 0;
  int t_ref = 0;
  int gap = 0;
  rts_sequencer #(.PORT_BASE_CYC(BASE)) dut (.clk_i(clk_i),
    .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_i(cmp_i), .charge_pin_o(chg),
    .emul_sel_o(emul), .reference_port_sel_o(rsel),
    .sensor_port_sel_o(ssel), .irq_n_o(irq_n_o));
  rts_rc_model rc (.clk_i(clk_i), .charge_i(chg), .emul_i(emul),
    .ref_i(rsel), .sns_i(ssel), .ref_t_i(ref_t), .sns_t_i(sns_t),
    .cmp_o(cmp_i));
  // ----
  // Clock, watchdog and pin observers
  // ----
  always #5 clk_i = ~clk_i;
  // One charge pulse per dummy slot
  always @(posedge chg)
    if (emul)
      n_dummy++;
  always @(posedge rsel)
  begin
    t_ref = n_cyc;
    order = {order[2:0], 1'b0};
  end
  always @(posedge ssel)
  begin
    gap = n_cyc - t_ref;
    order = {order[2:0], 1'b1};
  end
  always @(posedge clk_i)
  begin
    n_cyc++;
    if (n_cyc == 100000)
    begin
      n_fail++;
      finish_test();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  task automatic finish_test();
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] lo,
                     input logic [31:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("ERROR %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : chk
  task automatic wb_go(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && ++k < 20);
    chk({31'h0, wb_ack_o}, 32'h1, 32'h1);
    q = wb_dat_o;
    wb_i <= '0;
    @(posedge clk_i);
  endtask : wb_go
  task automatic chk_res(input logic [7:0] a, input logic [31:0] t,
                         input logic op);
    logic [31:0] q;
    logic [31:0] e;
    logic [31:0] f;
    int tol;
    e = op ? {16'h0, RES_ONES} : (t < SHORT_CYC) ? 32'h0 : t;
    tol = (e == {16'h0, RES_ONES} || e == 32'h0) ? 0 : 3;
    f = (tol == 0) ? e : 32'h0;
    wb_go(1'b0, a, 32'h0, q);
    chk(q, e - tol, e + tol);
    wb_go(1'b0, a + 8'h04, 32'h0, q);
    chk(q, f, f);
  endtask : chk_res
  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [31:0] q;
    int pre;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_go(1'b0, ADR_MASK, 32'h0, q);
    chk(q, 32'h0, 32'h0);
    wb_go(1'b1, 8'h40, 32'hFFFF_FFFF, q);
    wb_go(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      logic [1:0] fl;
      logic [31:0] cfg;
      fl = {i == 3, 1'b1};
      lfsr = nxt(lfsr);
      pre = (i == 0) ? 7 : (i == 1) ? 0 : int'(lfsr[1:0]);
      cfg = {26'h0, 2'(i), 3'(pre), 1'b0};
      ref_t <= (i == 3) ? 32'hFFFFF : 32'd900 + lfsr[7:2];
      sns_t <= (i == 2) ? 32'd400 + lfsr[15:8] : 32'd820 + lfsr[13:8];
      n_dummy = 0;
      wb_go(1'b1, ADR_MASK, {30'h0, msk[i]}, q);
      wb_go(1'b1, ADR_CTRL, {26'h0, 2'(i), 3'(pre), 1'b1}, q);
      wb_go(1'b1, ADR_CTRL, 32'h0B, q);
      q = 32'h0;
      for (int k = 0; k < 30000 && q[ST_DONE_BIT] !== 1'b1; k++)
        wb_go(1'b0, ADR_STATUS, 32'h0, q);
      chk(n_dummy, pre, pre);
      chk(order, 4'h5, 4'h5);
      if (i != 3)
        chk(gap, (i + 1) * BASE, (i + 1) * BASE + 3);
      if (i != 3)
        chk(q[14:9], 32'h0, 32'h0);
      chk(q[1:0], fl, fl);
      chk_res(ADR_REF_INT, ref_t, i == 3);
      chk_res(ADR_SNS_INT, sns_t, 1'b0);
      chk(irq_n_o, !(|(msk[i] & fl)), !(|(msk[i] & fl)));
      wb_go(1'b0, ADR_CTRL, 32'h0, q);
      chk(q, cfg, cfg);
      wb_go(1'b1, ADR_STATUS, 32'h3, q);
      wb_go(1'b0, ADR_STATUS, 32'h0, q);
      chk(q[8:0], 32'h0, 32'h0);
      chk(irq_n_o, 32'h1, 32'h1);
    end
    finish_test();
  end
endmodule : tb_rc_temperature_sequencer
